// file: inc/rmx_pkg.sv
// Package: constants and carrier types for the routing matrix
package rmx_pkg;

  // ****************************************************************
  // Matrix geometry
  // ****************************************************************
  localparam int NUM_SRC = 64;
  localparam int NUM_DST = 94;
  localparam int SEL_W = 6;
  localparam int CFG_BITS = 2048;
  localparam int SEL_BITS = NUM_DST * SEL_W;

  // ****************************************************************
  // Fixed source indices
  // ****************************************************************
  localparam logic [5:0] SRC_GND = 6'h00;
  localparam logic [5:0] SRC_VDD = 6'h3F;
  localparam int SRC_VIRT_BASE = 32;
  localparam int SRC_FAST_OSC = 53;
  localparam int SRC_DIVIDER = 54;
  localparam int SRC_SLOW_SLOW_OSCILLATOR = 55;
  localparam int SRC_SLOW_FAST_OSCILLATOR = 56;
  localparam logic [63:0] SRC_RESERVED_MASK =
    64'h1405_B300_00CC_8188;

  // ****************************************************************
  // Virtual input register
  // ****************************************************************
  localparam logic [7:0] VIRT_ADDR = 8'h4C;
  localparam int VIRT_CFG_LSB = 608;
  localparam int READBACK_LSB = 576;
  localparam int READBACK_MSB = 639;

  // ****************************************************************
  // Destination indices
  // ****************************************************************
  localparam int DST_HV_A_DATA = 16;
  localparam int DST_HV_A_OE = 17;
  localparam int DST_HV_B_DATA = 18;
  localparam int DST_HV_B_OE = 19;
  localparam int DST_HV_A_SLEEP = 25;
  localparam int DST_HV_B_SLEEP = 26;
  localparam int DST_PATTERN_GENERATOR_CLK = 29;
  localparam int DST_PATTERN_GENERATOR_RSTN = 30;
  localparam int DST_FSM_HOLD = 74;
  localparam int DST_FSM_UP = 75;
  localparam int DST_SLOW_OSC_EN = 90;
  localparam int DST_FAST_OSC_EN = 91;
  localparam int DST_REF_PD = 92;
  localparam logic [93:0] DST_RESERVED_MASK =
    94'h0281_F0FC_0000_7E06_01F0_F000;

  // ****************************************************************
  // Serial register port carrier
  // ****************************************************************
  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } rmx_req_t;

endpackage : rmx_pkg

// file: src/rmx_matrix.sv
// Routing crossbar with serially written virtual inputs
`timescale 1ns/1ns
module rmx_matrix (
  // Clock and reset
  input wire logic clock,
  input wire logic active_low_reset_input,
  // Configuration from nonvolatile memory
  input wire logic [2047:0] cfgBits,
  input wire logic cfgLoad,
  // Pin-side sources (asynchronous)
  input wire logic [63:0] srcPinRaw,
  // Serial register port
  input wire rmx_pkg::rmx_req_t req,
  output logic [7:0] rdData,
  // Routed destinations
  output logic [93:0] dstOut,
  output logic [93:0] dstUsed
);

  // ****************************************************************
  // Source classes
  // ****************************************************************
  // Every source index has one fixed class, settled at elaboration,
  // so no flop is spent on a constant, virtual or reserved line
  typedef enum logic [2:0] {
    KIND_LOW = 3'b000,
    KIND_HIGH = 3'b001,
    KIND_VIRT = 3'b010,
    KIND_PIN = 3'b011,
    KIND_RSVD = 3'b100
  } rmx_src_kind_t;

  function automatic rmx_src_kind_t src_kind(input int idx);
    rmx_src_kind_t kind;
    kind = KIND_PIN;
    if (idx == int'(rmx_pkg::SRC_GND)) begin
      kind = KIND_LOW;
    end else if (idx == int'(rmx_pkg::SRC_VDD)) begin
      kind = KIND_HIGH;
    end else if (idx >= rmx_pkg::SRC_VIRT_BASE &&
      idx < rmx_pkg::SRC_VIRT_BASE + 8) begin
      kind = KIND_VIRT;
    end else if (rmx_pkg::SRC_RESERVED_MASK[idx]) begin
      kind = KIND_RSVD;
    end
    return kind;
  endfunction : src_kind

  // Reserved destinations keep no select flops at all
  function automatic logic dst_live(input int idx);
    logic live;
    live = !rmx_pkg::DST_RESERVED_MASK[idx];
    return live;
  endfunction : dst_live

  // ****************************************************************
  // Request decode
  // ****************************************************************
  logic hitVirt;
  logic wrVirt;

  always_comb begin
    hitVirt = req.addr == rmx_pkg::VIRT_ADDR;
    // The rest of the read-back area is read-only: no other write lands
    wrVirt = req.wrEn && hitVirt;
  end

  // ****************************************************************
  // Virtual input register
  // ****************************************************************
  // A write in the cycle of a reload wins, so the host never loses it
  logic [7:0] virt_r;
  logic [7:0] virt_nxt;

  always_comb begin
    virt_nxt = virt_r;
    if (cfgLoad) begin
      virt_nxt = cfgBits[rmx_pkg::VIRT_CFG_LSB +: 8];
    end
    if (wrVirt) begin
      virt_nxt = req.wrData;
    end
  end

  always_ff @(posedge clock or negedge active_low_reset_input) begin
    if (!active_low_reset_input) begin
      virt_r <= 8'h00;
    end else begin
      virt_r <= virt_nxt;
    end
  end

  // Read-back returns the live virtual bits; other addresses read zero
  always_comb begin
    rdData = 8'h00;
    if (hitVirt) begin
      rdData = virt_r;
    end
  end

  // ****************************************************************
  // Source vector assembly
  // ****************************************************************
  wire logic [63:0] srcVec;

  genvar s;
  generate
    for (s = 0; s < rmx_pkg::NUM_SRC; s++) begin : gSrc
      localparam rmx_src_kind_t KIND = src_kind(s);
      if (KIND == KIND_LOW) begin : gLow
        assign srcVec[s] = 1'b0;
      end else if (KIND == KIND_HIGH) begin : gHigh
        assign srcVec[s] = 1'b1;
      end else if (KIND == KIND_VIRT) begin : gVirt
        assign srcVec[s] = virt_r[s-rmx_pkg::SRC_VIRT_BASE];
      end else if (KIND == KIND_RSVD) begin : gRsvd
        // Tied low so a stray select cannot float a destination
        assign srcVec[s] = 1'b0;
      end else begin : gPin
        // Two flops per live cell line; only the second one is read
        logic meta_r;
        logic sync_r;
        logic meta_nxt;
        logic sync_nxt;

        always_comb begin
          meta_nxt = srcPinRaw[s];
          sync_nxt = meta_r;
        end

        always_ff @(posedge clock or negedge active_low_reset_input) begin
          if (!active_low_reset_input) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
          end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
          end
        end

        assign srcVec[s] = sync_r;
      end
    end
  endgenerate
  // Sources 53..56 are plain cell lines: oscillators and divider

  // ****************************************************************
  // Crossbar
  // ****************************************************************
  // Each live destination keeps its own select; a field only changes
  // on a load, which keeps the routed level free of glitches
  genvar d;
  generate
    for (d = 0; d < rmx_pkg::NUM_DST; d++) begin : gDst
      if (!dst_live(d)) begin : gRes
        assign dstOut[d] = 1'b0;
        assign dstUsed[d] = 1'b0;
      end else begin : gLive
        logic [5:0] sel_r;
        logic [5:0] sel_nxt;

        always_comb begin
          sel_nxt = sel_r;
          if (cfgLoad) begin
            sel_nxt = cfgBits[d*rmx_pkg::SEL_W +: rmx_pkg::SEL_W];
          end
        end

        always_ff @(posedge clock or negedge active_low_reset_input) begin
          if (!active_low_reset_input) begin
            sel_r <= 6'h00;
          end else begin
            sel_r <= sel_nxt;
          end
        end

        // Reset leaves every select on the constant-low source
        assign dstOut[d] = srcVec[sel_r];
        assign dstUsed[d] = 1'b1;
      end
    end
  endgenerate

endmodule : rmx_matrix

// file: tb/rmx_matrix_assertions.sv
// Checker for the routing matrix ports
`timescale 1ns/1ns
module rmx_matrix_checker (
  // Clock and reset
  input logic clock,
  input logic active_low_reset_input,
  // Inputs
  input logic [2047:0] cfgBits,
  input logic cfgLoad,
  input rmx_pkg::rmx_req_t req,
  // Outputs
  input logic [7:0] rdData,
  input logic [93:0] dstOut,
  input logic [93:0] dstUsed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!active_low_reset_input);
  wire a = req.addr == 8'h4C;
  wire w = req.wrEn && a;
  wr_read_a: assert property (
    w ##1 a |-> rdData == $past(req.wrData)) else $error("write lost");
  other_addr_a: assert property (
    !a |-> rdData == 8'h00) else $error("stray read");
  load_init_a: assert property (
    cfgLoad && !w ##1 a |-> rdData == $past(cfgBits[615:608]))
    else $error("init lost");
  write_only_a: assert property (
    !cfgLoad && !w && a ##1 a |-> $stable(rdData)) else $error("drift");
  resv_dst_a: assert property (
    (dstOut & ~dstUsed) == 94'h0) else $error("reserved driven");
  gnd_src_a: assert property (
    cfgLoad && cfgBits[5:0] == 6'h00 |=> !dstOut[0]) else $error("gnd");
  vdd_last_a: assert property (
    cfgLoad && cfgBits[563:558] == 6'h3F |=> dstOut[93]) else $error("vdd");
  virt_route_a: assert property (
    cfgLoad && cfgBits[5:0] == 6'h22 ##1 a |-> dstOut[0] == rdData[2])
    else $error("virtual");
  rsvd_src_a: assert property (
    cfgLoad && cfgBits[545:540] == 6'h03 |=> !dstOut[90])
    else $error("reserved source");
  wr_c: cover property (w);
  load_c: cover property (cfgLoad && !w);
  stray_c: cover property (req.wrEn && !a);
  rsvd_c: cover property (cfgLoad && cfgBits[545:540] == 6'h03);
endmodule : rmx_matrix_checker

// file: tb/rmx_cell_model.sv
// Model of the on-chip cells feeding the sources
`timescale 1ns/1ns
module rmx_cell_model (
  // Source levels
  output logic [63:0] srcPinRaw
);
  // All high and steady, so a low result exposes a constant, reserved or low virtual slot
  assign srcPinRaw = 64'hFFFF_FFFF_FFFF_FFFF;
endmodule : rmx_cell_model

// file: tb/tb_rmx_matrix.sv
// Self-checking bench for the routing matrix
`timescale 1ns/1ns
module tb_rmx_matrix;
  logic clock = 1'b0;
  logic active_low_reset_input = 1'b0;
  logic [2047:0] cfgBits = '0;
  logic [2047:0] c;
  logic cfgLoad = 1'b0;
  logic [63:0] srcPinRaw;
  rmx_pkg::rmx_req_t req = '{1'b0, 8'h4C, 8'h00};
  logic [7:0] rdData;
  logic [93:0] dstOut;
  logic [93:0] dstUsed;
  int n_fail = 0;
  int total_checks = 0;
  // Rows: destination, source, level with virtual bits at A5
  int rows[17][3] = '{'{0,63,1}, '{93,63,1}, '{16,1,1}, '{19,5,1},
    '{25,53,1}, '{29,55,1}, '{30,56,1}, '{74,61,1},
    '{75,62,1}, '{90,3,0}, '{91,60,0}, '{92,0,0},
    '{12,63,0}, '{2,32,1}, '{3,33,0}, '{5,37,1}, '{7,38,0}};
  always #50 clock = ~clock;
  rmx_cell_model cell_u (.srcPinRaw(srcPinRaw));
  rmx_matrix dut_u (.clock(clock), .active_low_reset_input(active_low_reset_input), .cfgBits(cfgBits),
    .cfgLoad(cfgLoad), .srcPinRaw(srcPinRaw), .req(req),
    .rdData(rdData), .dstOut(dstOut), .dstUsed(dstUsed));
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic op(input logic [7:0] a, input logic [7:0] d,
    input logic ld, input logic [2047:0] v);
    @(posedge clock);
    req <= '{1'b1, a, d};
    cfgLoad <= ld;
    cfgBits <= v;
    @(posedge clock);
    req <= '{1'b0, 8'h4C, d};
    cfgLoad <= 1'b0;
    @(negedge clock);
  endtask : op
  task automatic complete_run;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge clock);
    active_low_reset_input <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      c = '0;
      c[615:608] = 8'hA5;
      c[rows[i][0]*6 +: 6] = 6'(rows[i][1]);
      op(8'h00, 8'hFF, 1'b1, c);
      chk(8'(dstOut[rows[i][0]]), 8'(rows[i][2]));
      chk(8'(dstUsed[rows[i][0]]), 8'(rows[i][0] != 12));
    end
    c[41:36] = 6'h00;
    c[5:0] = 6'h22;
    op(8'h00, 8'h00, 1'b1, c);
    chk(rdData, 8'hA5);
    chk(8'(dstOut[0]), 8'h01);
    op(8'h4C, 8'h5A, 1'b0, c);
    chk(rdData, 8'h5A);
    chk(8'(dstOut[0]), 8'h00);
    op(8'h4D, 8'hFF, 1'b0, c);
    chk(rdData, 8'h5A);
    // Write and reload on one edge: the write is kept
    op(8'h4C, 8'h0F, 1'b1, c);
    chk(rdData, 8'h0F);
    @(posedge clock) active_low_reset_input <= 1'b0;
    @(negedge clock);
    chk(8'(dstOut[0]), 8'h00);
    complete_run;
  end
  initial begin
    #200000;
    n_fail++;
    complete_run;
  end
endmodule : tb_rmx_matrix
bind rmx_matrix rmx_matrix_checker chk_u (.clock(clock), .active_low_reset_input(active_low_reset_input),
  .cfgBits(cfgBits), .cfgLoad(cfgLoad), .req(req), .rdData(rdData),
  .dstOut(dstOut), .dstUsed(dstUsed));
